// file: rtl/txsec_cfg.svh
`ifndef TXSEC_CFG_SVH
`define TXSEC_CFG_SVH
`define TXSEC_ADDR_BEACON_CTRL 10'h01A
`define TXSEC_ADDR_NORMAL_CTRL 10'h01B
`define TXSEC_ADDR_SLOT1_CTRL 10'h01C
`define TXSEC_ADDR_SLOT2_CTRL 10'h01D
`define TXSEC_ADDR_TX_RESULT 10'h024
`define TXSEC_ADDR_SEC_CTRL_A 10'h02C
`define TXSEC_ADDR_SEC_CTRL_B 10'h02D
`define TXSEC_ADDR_INT_FLAGS 10'h031
`define TXSEC_ADDR_INT_EN 10'h032
`define TXSEC_ADDR_SEC_CTRL_C 10'h037
`define TXSEC_KEY_NORMAL_BASE 10'h280
`define TXSEC_KEY_SLOT1_BASE 10'h290
`define TXSEC_KEY_SLOT2_BASE 10'h2A0
`define TXSEC_KEY_RX_BASE 10'h2B0
`define TXSEC_BIT_GO 0
`define TXSEC_BIT_SECEN 1
`define TXSEC_BIT_ENCRYPT_DISABLE 0
`define TXSEC_BIT_DECRYPT_DISABLE 1
`define TXSEC_RESET_BYTE 8'h00
`define TXSEC_ENGINE_CYCLES 8'h10
`endif

// file: rtl/txsec_pkg.sv
package txsec_pkg;
    typedef enum logic [2:0] {
        TXSEC_SUITE_NONE, TXSEC_SUITE_CTR, TXSEC_SUITE_CCM128, TXSEC_SUITE_CCM64,
        TXSEC_SUITE_CCM32, TXSEC_SUITE_CBC128, TXSEC_SUITE_CBC64, TXSEC_SUITE_CBC32
    } txsec_suite_t;
    typedef enum logic [1:0] {
        TXSEC_FIFO_NORMAL, TXSEC_FIFO_SLOT1, TXSEC_FIFO_SLOT2, TXSEC_FIFO_BEACON
    } txsec_fifo_t;
    typedef enum logic [1:0] {TXSEC_IDLE, TXSEC_CIPHER, TXSEC_SEND} txsec_state_t;
endpackage : txsec_pkg

// file: rtl/txsec_ctrl.sv
`timescale 1ns/1ns
`include "txsec_cfg.svh"
// Summary of operation
// - aes-128 engine control offering seven selectable suites for frames.
// - key store holds four 128-bit keys: three transmit, one receive.
// - normal, slot1, slot2 keys sit at 0x280, 0x290, 0x2a0 ranges.
// - beacon fifo shares the slot2 key range.
// - per-fifo 3-bit suite fields at 0x2c, 0x37 low/high, 0x2d bits 6:4.
// - suite code: none, ctr, ccm 128/64/32, cbc-mac 128/64/32.
// - secure enable plus trigger starts encrypted send; normal at 0x1b.
// - slot1 0x1c, slot2 0x1d, beacon 0x1a, bits 1 and 0.
// - normal done sets flag bit 0; status bit 0 is 1 on failure.
// - normal retry count at 0x24 bits 7:6.
// - channel busy failure sets 0x24 bit 5.
// - slot done sets flag bit 1 or 2; status 1 means success.
// - slot retry counts in bits 7:6 of 0x1c and 0x1d.
// - slot no-time failure sets 0x24 bit 3 or 4.
// - eight flags at 0x31 with enables at same bits of 0x32.
// - 0x2d bit 1 disables decryption, bit 0 disables encryption.
module txsec_ctrl (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [9:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic tx_done_i,
    input wire logic tx_fail_i,
    input wire logic tx_cca_fail_i,
    input wire logic tx_no_time_i,
    input wire logic [1:0] tx_retries_i,
    input wire logic [3:0] other_flags_set_i,
    output logic tx_start_o,
    output logic [1:0] tx_fifo_o,
    output logic [2:0] tx_suite_o,
    output logic [127:0] tx_key_o,
    output logic tx_encrypt_o,
    output logic decrypt_disable_o,
    output logic int_o
);
    logic [7:0] key_mem [0:63];
    logic [7:0] beacon_ctrl_reg, beacon_ctrl_next;
    logic [7:0] normal_ctrl_reg, normal_ctrl_next;
    logic [7:0] slot1_ctrl_reg, slot1_ctrl_next;
    logic [7:0] slot2_ctrl_reg, slot2_ctrl_next;
    logic [7:0] result_reg, result_next;
    logic [7:0] sec_a_reg, sec_a_next;
    logic [7:0] sec_b_reg, sec_b_next;
    logic [7:0] sec_c_reg, sec_c_next;
    logic [7:0] flags_reg, flags_next;
    logic [7:0] int_en_reg, int_en_next;
    logic [7:0] rdata_reg, rdata_next;
    logic start_reg, start_next;
    logic [1:0] fifo_reg, fifo_next;
    logic [2:0] suite_reg, suite_next;
    logic enc_reg, enc_next;
    logic int_reg, int_next;
    logic [7:0] cnt_reg, cnt_next;
    txsec_pkg::txsec_state_t state_reg, state_next;
    logic [127:0] key_sel;
    logic key_hit;
    logic [5:0] key_idx;
    logic [1:0] sel_fifo;
    logic sel_go;
    logic [2:0] sel_suite;
    logic sel_secen;

    assign key_hit = (reg_addr_i >= `TXSEC_KEY_NORMAL_BASE) && (reg_addr_i <= 10'h2BF);
    assign key_idx = reg_addr_i[5:0];

    // key rows; beacon reuses slot2 row
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            key_sel[8*i +: 8] = key_mem[{fifo_reg == 2'd3 ? 2'd2 : fifo_reg, i[3:0]}];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reg_wr_i && key_hit) begin
            key_mem[key_idx] <= reg_wdata_i;
        end
    end

    // pick next pending trigger, normal first
    always_comb begin
        sel_go = 1'b1;
        sel_fifo = 2'd0;
        sel_suite = sec_a_reg[2:0];
        sel_secen = normal_ctrl_reg[`TXSEC_BIT_SECEN];
        if (normal_ctrl_reg[`TXSEC_BIT_GO]) begin
            sel_fifo = 2'd0;
        end else if (slot1_ctrl_reg[`TXSEC_BIT_GO]) begin
            sel_fifo = 2'd1;
            sel_suite = sec_c_reg[2:0];
            sel_secen = slot1_ctrl_reg[`TXSEC_BIT_SECEN];
        end else if (slot2_ctrl_reg[`TXSEC_BIT_GO]) begin
            sel_fifo = 2'd2;
            sel_suite = sec_c_reg[5:3];
            sel_secen = slot2_ctrl_reg[`TXSEC_BIT_SECEN];
        end else if (beacon_ctrl_reg[`TXSEC_BIT_GO]) begin
            sel_fifo = 2'd3;
            sel_suite = sec_b_reg[6:4];
            sel_secen = beacon_ctrl_reg[`TXSEC_BIT_SECEN];
        end else begin
            sel_go = 1'b0;
        end
    end

    always_comb begin
        beacon_ctrl_next = beacon_ctrl_reg;
        normal_ctrl_next = normal_ctrl_reg;
        slot1_ctrl_next = slot1_ctrl_reg;
        slot2_ctrl_next = slot2_ctrl_reg;
        result_next = result_reg;
        sec_a_next = sec_a_reg;
        sec_b_next = sec_b_reg;
        sec_c_next = sec_c_reg;
        flags_next = flags_reg;
        int_en_next = int_en_reg;
        rdata_next = rdata_reg;
        state_next = state_reg;
        start_next = 1'b0;
        fifo_next = fifo_reg;
        suite_next = suite_reg;
        enc_next = enc_reg;
        cnt_next = cnt_reg;
        if (reg_wr_i) begin
            if (reg_addr_i == `TXSEC_ADDR_BEACON_CTRL) begin
                beacon_ctrl_next = {6'h00, reg_wdata_i[1:0]};
            end else if (reg_addr_i == `TXSEC_ADDR_NORMAL_CTRL) begin
                normal_ctrl_next = reg_wdata_i;
            end else if (reg_addr_i == `TXSEC_ADDR_SLOT1_CTRL) begin
                slot1_ctrl_next = {slot1_ctrl_reg[7:6], reg_wdata_i[5:0]};
            end else if (reg_addr_i == `TXSEC_ADDR_SLOT2_CTRL) begin
                slot2_ctrl_next = {slot2_ctrl_reg[7:6], reg_wdata_i[5:0]};
            end else if (reg_addr_i == `TXSEC_ADDR_SEC_CTRL_A) begin
                sec_a_next = reg_wdata_i;
            end else if (reg_addr_i == `TXSEC_ADDR_SEC_CTRL_B) begin
                sec_b_next = {1'b0, reg_wdata_i[6:4], 2'b00, reg_wdata_i[1:0]};
            end else if (reg_addr_i == `TXSEC_ADDR_SEC_CTRL_C) begin
                sec_c_next = reg_wdata_i;
            end else if (reg_addr_i == `TXSEC_ADDR_INT_EN) begin
                int_en_next = reg_wdata_i;
            end
        end
        // reading the flags clears them; a same-cycle set still lands
        if (reg_rd_i && reg_addr_i == `TXSEC_ADDR_INT_FLAGS) begin
            flags_next = 8'h00;
        end
        flags_next[7:4] = flags_next[7:4] | other_flags_set_i;
        if (reg_rd_i) begin
            if (reg_addr_i == `TXSEC_ADDR_BEACON_CTRL) begin
                rdata_next = beacon_ctrl_reg;
            end else if (reg_addr_i == `TXSEC_ADDR_NORMAL_CTRL) begin
                rdata_next = normal_ctrl_reg;
            end else if (reg_addr_i == `TXSEC_ADDR_SLOT1_CTRL) begin
                rdata_next = slot1_ctrl_reg;
            end else if (reg_addr_i == `TXSEC_ADDR_SLOT2_CTRL) begin
                rdata_next = slot2_ctrl_reg;
            end else if (reg_addr_i == `TXSEC_ADDR_TX_RESULT) begin
                rdata_next = result_reg;
            end else if (reg_addr_i == `TXSEC_ADDR_SEC_CTRL_A) begin
                rdata_next = sec_a_reg;
            end else if (reg_addr_i == `TXSEC_ADDR_SEC_CTRL_B) begin
                rdata_next = sec_b_reg;
            end else if (reg_addr_i == `TXSEC_ADDR_SEC_CTRL_C) begin
                rdata_next = sec_c_reg;
            end else if (reg_addr_i == `TXSEC_ADDR_INT_FLAGS) begin
                rdata_next = flags_reg;
            end else if (reg_addr_i == `TXSEC_ADDR_INT_EN) begin
                rdata_next = int_en_reg;
            end else if (key_hit) begin
                rdata_next = 8'h00;
            end else begin
                rdata_next = 8'h00;
            end
        end
        case (state_reg)
            txsec_pkg::TXSEC_IDLE: begin
                if (sel_go) begin
                    fifo_next = sel_fifo;
                    suite_next = sel_suite;
                    enc_next = sel_secen && (sel_suite != txsec_pkg::TXSEC_SUITE_NONE)
                        && !sec_b_reg[`TXSEC_BIT_ENCRYPT_DISABLE];
                    cnt_next = `TXSEC_ENGINE_CYCLES;
                    state_next = txsec_pkg::TXSEC_CIPHER;
                end
            end
            txsec_pkg::TXSEC_CIPHER: begin
                // engine pass only when encrypting
                if (!enc_reg || cnt_reg == 8'h00) begin
                    start_next = 1'b1;
                    state_next = txsec_pkg::TXSEC_SEND;
                end else begin
                    cnt_next = cnt_reg - 8'h01;
                end
            end
            default: begin
                if (tx_done_i) begin
                    state_next = txsec_pkg::TXSEC_IDLE;
                    case (fifo_reg)
                        2'd0: begin
                            normal_ctrl_next[`TXSEC_BIT_GO] = 1'b0;
                            flags_next[0] = 1'b1;
                            result_next[0] = tx_fail_i;
                            result_next[7:6] = tx_retries_i;
                        end
                        2'd1: begin
                            slot1_ctrl_next[`TXSEC_BIT_GO] = 1'b0;
                            slot1_ctrl_next[7:6] = tx_retries_i;
                            flags_next[1] = 1'b1;
                            result_next[1] = !tx_fail_i;
                            result_next[3] = tx_no_time_i;
                        end
                        2'd2: begin
                            slot2_ctrl_next[`TXSEC_BIT_GO] = 1'b0;
                            slot2_ctrl_next[7:6] = tx_retries_i;
                            flags_next[2] = 1'b1;
                            result_next[2] = !tx_fail_i;
                            result_next[4] = tx_no_time_i;
                        end
                        default: begin
                            beacon_ctrl_next[`TXSEC_BIT_GO] = 1'b0;
                        end
                    endcase
                    result_next[5] = tx_fail_i && tx_cca_fail_i;
                end
            end
        endcase
        int_next = |(flags_next & int_en_next);
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            beacon_ctrl_reg <= `TXSEC_RESET_BYTE;
            normal_ctrl_reg <= `TXSEC_RESET_BYTE;
            slot1_ctrl_reg <= `TXSEC_RESET_BYTE;
            slot2_ctrl_reg <= `TXSEC_RESET_BYTE;
            result_reg <= `TXSEC_RESET_BYTE;
            sec_a_reg <= `TXSEC_RESET_BYTE;
            sec_b_reg <= `TXSEC_RESET_BYTE;
            sec_c_reg <= `TXSEC_RESET_BYTE;
            flags_reg <= `TXSEC_RESET_BYTE;
            int_en_reg <= `TXSEC_RESET_BYTE;
            rdata_reg <= `TXSEC_RESET_BYTE;
            state_reg <= txsec_pkg::TXSEC_IDLE;
            start_reg <= 1'b0;
            fifo_reg <= 2'd0;
            suite_reg <= 3'd0;
            enc_reg <= 1'b0;
            int_reg <= 1'b0;
            cnt_reg <= 8'h00;
        end else begin
            beacon_ctrl_reg <= beacon_ctrl_next;
            normal_ctrl_reg <= normal_ctrl_next;
            slot1_ctrl_reg <= slot1_ctrl_next;
            slot2_ctrl_reg <= slot2_ctrl_next;
            result_reg <= result_next;
            sec_a_reg <= sec_a_next;
            sec_b_reg <= sec_b_next;
            sec_c_reg <= sec_c_next;
            flags_reg <= flags_next;
            int_en_reg <= int_en_next;
            rdata_reg <= rdata_next;
            state_reg <= state_next;
            start_reg <= start_next;
            fifo_reg <= fifo_next;
            suite_reg <= suite_next;
            enc_reg <= enc_next;
            int_reg <= int_next;
            cnt_reg <= cnt_next;
        end
    end

    logic [127:0] key_out_reg;
    always_ff @(posedge clk_i) begin
        key_out_reg <= key_sel;
    end

    assign reg_rdata_o = rdata_reg;
    assign tx_start_o = start_reg;
    assign tx_fifo_o = fifo_reg;
    assign tx_suite_o = suite_reg;
    assign tx_key_o = key_out_reg;
    assign tx_encrypt_o = enc_reg;
    assign decrypt_disable_o = sec_b_reg[`TXSEC_BIT_DECRYPT_DISABLE];
    assign int_o = int_reg;

    property p_clear_send;
        @(posedge clk_i) disable iff (sys_rst_i)
        (tx_start_o && tx_suite_o == 3'b000) |-> !tx_encrypt_o;
    endproperty
    a_clear_send: assert property (p_clear_send) else $error("suite none encrypted");

    property p_normal_done;
        @(posedge clk_i) disable iff (sys_rst_i)
        (state_reg == txsec_pkg::TXSEC_SEND && tx_done_i && fifo_reg == 2'd0)
            |=> flags_reg[0] && result_reg[0] == $past(tx_fail_i);
    endproperty
    a_normal_done: assert property (p_normal_done) else $error("normal done wrong");

    property p_slot1_done;
        @(posedge clk_i) disable iff (sys_rst_i)
        (state_reg == txsec_pkg::TXSEC_SEND && tx_done_i && fifo_reg == 2'd1)
            |=> flags_reg[1] && result_reg[1] != $past(tx_fail_i)
            && slot1_ctrl_reg[7:6] == $past(tx_retries_i);
    endproperty
    a_slot1_done: assert property (p_slot1_done) else $error("slot1 done wrong");

    property p_slot2_done;
        @(posedge clk_i) disable iff (sys_rst_i)
        (state_reg == txsec_pkg::TXSEC_SEND && tx_done_i && fifo_reg == 2'd2)
            |=> flags_reg[2] && result_reg[2] != $past(tx_fail_i)
            && result_reg[4] == $past(tx_no_time_i);
    endproperty
    a_slot2_done: assert property (p_slot2_done) else $error("slot2 done wrong");

    property p_normal_first;
        @(posedge clk_i) disable iff (sys_rst_i)
        (state_reg == txsec_pkg::TXSEC_IDLE && normal_ctrl_reg[`TXSEC_BIT_GO])
            |=> state_reg == txsec_pkg::TXSEC_CIPHER && fifo_reg == 2'd0;
    endproperty
    a_normal_first: assert property (p_normal_first) else $error("normal fifo not taken");

    property p_int_mask;
        @(posedge clk_i) disable iff (sys_rst_i)
        ##1 int_o == |(flags_reg & int_en_reg);
    endproperty
    a_int_mask: assert property (p_int_mask) else $error("interrupt mask mismatch");
endmodule : txsec_ctrl

// file: tb/txsec_xmit_model.sv
`timescale 1ns/1ns
// transmitter stand-in: answers each start with one done pulse after a delay
module txsec_xmit_model #(
    parameter int DELAY = 6
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic tx_start_i,
    input wire logic fail_i,
    input wire logic cca_i,
    input wire logic no_time_i,
    input wire logic [1:0] retries_i,
    output logic tx_done_o,
    output logic tx_fail_o,
    output logic tx_cca_fail_o,
    output logic tx_no_time_o,
    output logic [1:0] tx_retries_o
);
    int cnt = 0;
    logic done = 1'b0;
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt <= 0;
            done <= 1'b0;
        end else begin
            done <= (cnt == 1);
            if (tx_start_i)
                cnt <= DELAY;
            else if (cnt > 0)
                cnt <= cnt - 1;
        end
    end
    assign tx_done_o = done;
    // results only mean something with done; show inverted values otherwise
    assign tx_fail_o = done ? fail_i : ~fail_i;
    assign tx_cca_fail_o = done ? cca_i : ~cca_i;
    assign tx_no_time_o = done ? no_time_i : ~no_time_i;
    assign tx_retries_o = done ? retries_i : ~retries_i;
endmodule : txsec_xmit_model

// file: tb/txsec_ctrl_tb.sv
`timescale 1ns/1ns
`include "txsec_cfg.svh"
module txsec_ctrl_tb;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [9:0] reg_addr_i = 10'h000;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o;
    logic [7:0] d;
    logic tx_done_i, tx_fail_i, tx_cca_fail_i, tx_no_time_i;
    logic [1:0] tx_retries_i, tx_fifo_o;
    logic [3:0] other_flags_set_i = 4'h0;
    logic tx_start_o, tx_encrypt_o, decrypt_disable_o, int_o;
    logic [2:0] tx_suite_o;
    logic [127:0] tx_key_o;
    logic [127:0] keys [3];
    logic r_fail = 1'b0;
    logic r_cca = 1'b0;
    logic r_nt = 1'b0;
    logic [1:0] r_ret = 2'h0;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    initial forever #2 clk_i = ~clk_i;
    txsec_ctrl uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .tx_done_i(tx_done_i), .tx_fail_i(tx_fail_i),
        .tx_cca_fail_i(tx_cca_fail_i), .tx_no_time_i(tx_no_time_i),
        .tx_retries_i(tx_retries_i), .other_flags_set_i(other_flags_set_i),
        .tx_start_o(tx_start_o), .tx_fifo_o(tx_fifo_o), .tx_suite_o(tx_suite_o),
        .tx_key_o(tx_key_o), .tx_encrypt_o(tx_encrypt_o),
        .decrypt_disable_o(decrypt_disable_o), .int_o(int_o));
    txsec_xmit_model xm (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .tx_start_i(tx_start_o),
        .fail_i(r_fail), .cca_i(r_cca), .no_time_i(r_nt), .retries_i(r_ret),
        .tx_done_o(tx_done_i), .tx_fail_o(tx_fail_i), .tx_cca_fail_o(tx_cca_fail_i),
        .tx_no_time_o(tx_no_time_i), .tx_retries_o(tx_retries_i));
    task automatic end_of_test();
        $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [9:0] a, input logic [7:0] v);
        @(posedge clk_i) #1;
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = v;
        @(posedge clk_i) #1;
        reg_wr_i = 1'b0;
    endtask : wr
    task automatic rd(input logic [9:0] a);
        @(posedge clk_i) #1;
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        @(posedge clk_i) #1;
        reg_rd_i = 1'b0;
        d = reg_rdata_o;
    endtask : rd
    task automatic rdc(input logic [9:0] a, input logic [7:0] exp);
        rd(a);
        check(128'(d), 128'(exp));
    endtask : rdc
    // trigger one fifo, then time and inspect the start it produces
    task automatic run(input logic [9:0] ca, input logic [7:0] cv, input logic [1:0] f,
            input logic [2:0] s, input logic enc);
        int n;
        n = 0;
        wr(ca, cv);
        while (tx_start_o !== 1'b1 && n < 40) begin
            @(posedge clk_i) #1;
            n++;
        end
        check(128'(n), enc ? 128'(`TXSEC_ENGINE_CYCLES) + 128'h2 : 128'h2);
        check(128'(tx_fifo_o), 128'(f));
        check(128'(tx_encrypt_o), 128'(enc));
        check(128'(tx_suite_o), 128'(s));
        if (enc)
            check(tx_key_o, keys[(f == 2'h3) ? 2 : f]);
        repeat (12) @(posedge clk_i);
        #1;
    endtask : run
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            end_of_test();
        end
    end
    initial begin
        repeat (8) @(posedge clk_i);
        #1 sys_rst_i = 1'b0;
        rdc(`TXSEC_ADDR_INT_FLAGS, 8'h00);
        rdc(`TXSEC_ADDR_TX_RESULT, 8'h00);
        rdc(10'h03F, 8'h00);
        for (int f = 0; f < 3; f++) begin
            for (int i = 0; i < 16; i++) begin
                keys[f][8*i+:8] = 8'(8'h11 * (f + 1) + i);
                wr(10'(`TXSEC_KEY_NORMAL_BASE + 16 * f + i), keys[f][8*i+:8]);
            end
        end
        rdc(10'h285, 8'h00);
        wr(`TXSEC_ADDR_INT_EN, 8'h07);
        rdc(`TXSEC_ADDR_INT_EN, 8'h07);
        r_fail = 1'b1;
        r_cca = 1'b1;
        r_ret = 2'h3;
        for (int s = 1; s < 8; s++) begin
            wr(`TXSEC_ADDR_SEC_CTRL_A, 8'(s));
            run(`TXSEC_ADDR_NORMAL_CTRL, 8'h03, 2'h0, 3'(s), 1'b1);
        end
        rdc(`TXSEC_ADDR_TX_RESULT, 8'he1);
        rd(`TXSEC_ADDR_NORMAL_CTRL);
        check(128'(d[0]), 128'h0);
        check(128'(int_o), 128'h1);
        rdc(`TXSEC_ADDR_INT_FLAGS, 8'h01);
        @(posedge clk_i) #1;
        check(128'(int_o), 128'h0);
        rdc(`TXSEC_ADDR_INT_FLAGS, 8'h00);
        r_fail = 1'b0;
        r_ret = 2'h1;
        wr(`TXSEC_ADDR_SEC_CTRL_A, 8'h03);
        run(`TXSEC_ADDR_NORMAL_CTRL, 8'h01, 2'h0, 3'h3, 1'b0);
        wr(`TXSEC_ADDR_SEC_CTRL_A, 8'h00);
        run(`TXSEC_ADDR_NORMAL_CTRL, 8'h03, 2'h0, 3'h0, 1'b0);
        wr(`TXSEC_ADDR_SEC_CTRL_A, 8'h02);
        wr(`TXSEC_ADDR_SEC_CTRL_B, 8'h01);
        run(`TXSEC_ADDR_NORMAL_CTRL, 8'h03, 2'h0, 3'h2, 1'b0);
        rdc(`TXSEC_ADDR_TX_RESULT, 8'h40);
        wr(`TXSEC_ADDR_SEC_CTRL_B, 8'h02);
        check(128'(decrypt_disable_o), 128'h1);
        rdc(`TXSEC_ADDR_INT_FLAGS, 8'h01);
        r_cca = 1'b0;
        r_ret = 2'h2;
        wr(`TXSEC_ADDR_SEC_CTRL_C, 8'h35);
        run(`TXSEC_ADDR_SLOT1_CTRL, 8'h03, 2'h1, 3'h5, 1'b1);
        rdc(`TXSEC_ADDR_TX_RESULT, 8'h42);
        rd(`TXSEC_ADDR_SLOT1_CTRL);
        check(128'(d & 8'hc1), 128'h80);
        rdc(`TXSEC_ADDR_INT_FLAGS, 8'h02);
        r_fail = 1'b1;
        r_nt = 1'b1;
        run(`TXSEC_ADDR_SLOT1_CTRL, 8'h03, 2'h1, 3'h5, 1'b1);
        rdc(`TXSEC_ADDR_TX_RESULT, 8'h48);
        r_ret = 2'h0;
        run(`TXSEC_ADDR_SLOT2_CTRL, 8'h03, 2'h2, 3'h6, 1'b1);
        rd(`TXSEC_ADDR_TX_RESULT);
        check(128'(d & 8'h14), 128'h10);
        rd(`TXSEC_ADDR_SLOT2_CTRL);
        check(128'(d & 8'hc1), 128'h00);
        rdc(`TXSEC_ADDR_INT_FLAGS, 8'h06);
        wr(`TXSEC_ADDR_SEC_CTRL_B, 8'h70);
        run(`TXSEC_ADDR_BEACON_CTRL, 8'h03, 2'h3, 3'h7, 1'b1);
        rdc(`TXSEC_ADDR_INT_FLAGS, 8'h00);
        @(posedge clk_i) #1;
        other_flags_set_i = 4'hf;
        @(posedge clk_i) #1;
        other_flags_set_i = 4'h0;
        @(posedge clk_i) #1;
        check(128'(int_o), 128'h0);
        rdc(`TXSEC_ADDR_INT_FLAGS, 8'hf0);
        end_of_test();
    end
endmodule : txsec_ctrl_tb
